// [dsd_pkg.sv]
// Constants for the opcode decoder: opcodes, fields, counts, registers.
// Assumes a 16-bit instruction word and a 32-bit AXI4-Lite register bus.
`default_nettype none
package dsd_pkg;
  // ----------------------------------------------------------------
  // Decoded operations
  // ----------------------------------------------------------------
  localparam int OP_W = 5;
  localparam logic [OP_W-1:0] OP_NONE         = 5'h00;
  localparam logic [OP_W-1:0] OP_PULL_ACC     = 5'h01;
  localparam logic [OP_W-1:0] OP_PULL_MEM     = 5'h02;
  localparam logic [OP_W-1:0] OP_SAVE_MEM     = 5'h03;
  localparam logic [OP_W-1:0] OP_PUSH_ACC     = 5'h04;
  localparam logic [OP_W-1:0] OP_COND_RETURN  = 5'h05;
  localparam logic [OP_W-1:0] OP_REPEAT_IMM   = 5'h06;
  localparam logic [OP_W-1:0] OP_REPEAT_MEM   = 5'h07;
  localparam logic [OP_W-1:0] OP_STORE_HIGH   = 5'h08;
  localparam logic [OP_W-1:0] OP_STORE_LOW    = 5'h09;
  localparam logic [OP_W-1:0] OP_AUX_MINUS    = 5'h0A;
  localparam logic [OP_W-1:0] OP_SET_BIT      = 5'h0B;
  localparam logic [OP_W-1:0] OP_ACC_MINUS_P  = 5'h0C;
  localparam logic [OP_W-1:0] OP_P_SHIFT_SEL  = 5'h0D;
  localparam logic [OP_W-1:0] OP_SQUARE_MINUS = 5'h0E;
  localparam logic [OP_W-1:0] OP_STATUS0      = 5'h0F;
  localparam logic [OP_W-1:0] OP_STATUS1      = 5'h10;
  localparam logic [OP_W-1:0] OP_LONG_IMM     = 5'h11;
  localparam logic [OP_W-1:0] OP_MINUS_SHIFT  = 5'h12;
  localparam logic [OP_W-1:0] OP_MINUS_LONG   = 5'h13;
  localparam logic [OP_W-1:0] OP_MINUS_BORROW = 5'h14;
  localparam logic [OP_W-1:0] OP_MINUS_TEMP   = 5'h15;
  localparam logic [OP_W-1:0] OP_MINUS_IMM    = 5'h16;
  localparam logic [OP_W-1:0] OP_XOR_HIGH     = 5'h17;
  localparam logic [OP_W-1:0] OP_CLR_LOAD_RND = 5'h18;
  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [15:0] W_PULL_ACC = 16'hBE32;
  localparam logic [15:0] W_PUSH_ACC = 16'hBE3C;
  localparam logic [15:0] W_ACC_MINUS_P = 16'hBE05;
  localparam logic [15:0] W_XOR_HIGH = 16'hBE83;
  localparam logic [11:0] T_SET_BIT = 12'hBE4;
  localparam logic [11:0] T_MINUS_LONG = 12'hBFA;
  localparam logic [5:0]  T_COND_RETURN = 6'h3B;
  localparam logic [3:0]  N_STORE_ACC = 4'h9;
  localparam logic [3:0]  N_MINUS_SHIFT = 4'h3;
  localparam logic [7:0] H_PULL_MEM = 8'h8A;
  localparam logic [7:0] H_SAVE_MEM = 8'h76;
  localparam logic [7:0] H_REPEAT_IMM = 8'hBB;
  localparam logic [7:0] H_REPEAT_MEM = 8'h0B;
  localparam logic [7:0] H_AUX_MINUS = 8'h7C;
  localparam logic [7:0] H_P_SHIFT_SEL = 8'hBF;
  localparam logic [7:0] H_SQUARE_MINUS = 8'h53;
  localparam logic [7:0] H_STATUS0 = 8'h8E;
  localparam logic [7:0] H_STATUS1 = 8'h8F;
  localparam logic [7:0] H_LONG_IMM = 8'hAE;
  localparam logic [7:0] H_MINUS_BORROW = 8'h64;
  localparam logic [7:0] H_MINUS_TEMP = 8'h67;
  localparam logic [7:0] H_MINUS_IMM = 8'hBA;
  localparam logic [7:0] H_CLR_LOAD_RND = 8'h68;
  // Control bit nibbles and their select codes
  localparam logic [3:0] B_CARRY = 4'hF;
  localparam logic [3:0] B_BLOCK_PROG = 4'h5;
  localparam logic [3:0] B_INT_DIS = 4'h1;
  localparam logic [3:0] B_OVF_MODE = 4'h3;
  localparam logic [3:0] B_TEST = 4'hB;
  localparam logic [3:0] B_EXT_FLAG = 4'hD;
  localparam logic [3:0] B_SIGN_EXT = 4'h7;
  localparam logic [2:0] SEL_CARRY = 3'h0;
  localparam logic [2:0] SEL_BLOCK_PROG = 3'h1;
  localparam logic [2:0] SEL_INT_DIS = 3'h2;
  localparam logic [2:0] SEL_OVF_MODE = 3'h3;
  localparam logic [2:0] SEL_TEST = 3'h4;
  localparam logic [2:0] SEL_EXT_FLAG = 3'h5;
  localparam logic [2:0] SEL_SIGN_EXT = 3'h6;
  // Field positions
  localparam int POS_HALF = 11;
  localparam int POS_TP_HI = 9;
  localparam int POS_TP_LO = 8;
  // Words and cycles
  localparam logic [1:0] WORDS_ONE = 2'h1;
  localparam logic [1:0] WORDS_TWO = 2'h2;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_RET_TAKEN = 3'h4;
  localparam logic [2:0] CYC_RET_SKIP = 3'h2;
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_COUNT = 4'h8;
  localparam logic [ADDR_W-1:0] REG_LAST = 4'hC;
  localparam int CTRL_EN = 0;
  localparam int CTRL_ABORT = 1;
  localparam logic RESET_EN = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10
  } dsd_state_e;
endpackage
`default_nettype wire

// [dsd_decoder.sv]
// Opcode decoder for stack, store, subtract and immediate instructions.
// Assumes the fetch unit and the AXI4-Lite master share aclk.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Word BE32 decodes to stack pull into low accumulator, 1 word 1 cycle.
// - Upper byte 8A pulls stack top to addressed memory, 1 word 1 cycle.
// - Upper byte 76 pushes addressed memory word onto stack, 1/1.
// - Word BE3C pushes low accumulator onto stack, 1 word 1 cycle.
// - Top six bits 111011: conditional return, 4 cycles taken, 2 not.
// - Upper byte BB loads repeat counter from 8-bit constant, 1 cycle.
// - Upper byte 0B takes repeat count from addressed memory, 1/1.
// - Nibble 9 stores shifted accumulator; bit 11 picks half, 3-bit shift.
// - Upper byte 7C subtracts 8-bit constant from current aux register.
// - BE4x sets the control bit chosen by low nibble F, 5, 1, 3, B, D or 7; other nibbles decode to none.
// - Word BE05 subtracts product register from accumulator, 1/1.
// - Upper byte BF, except BFAx, sets product output shift mode, 1 cycle.
// - Upper byte 53 squares operand, subtracts previous product, 1/1.
// - Upper bytes 8E and 8F store status register 0 or 1.
// - Upper byte AE takes a 16-bit constant word; 2 words 2 cycles.
// - Nibble 3 subtracts operand shifted by bits 11..8, 1 cycle.
// - BFAx plus constant word subtracts shifted constant, 2/2.
// - Upper byte 64 subtracts operand with borrow, 1 cycle.
// - Upper byte 67 subtracts operand shifted by temporary register.
// - Upper byte BA subtracts 8-bit constant from accumulator, 1/1.
// - Word BE83 plus constant XORs constant shifted by 16, 2/2.
// - Upper byte 68 clears low, loads high accumulator rounded, 1/1.
module dsd_decoder (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_word,
  output logic             fetch_ready,
  output logic             dec_valid,
  output logic [4:0]       dec_op,
  output logic [1:0]       dec_words,
  output logic [2:0]       dec_cycles,
  output logic [2:0]       dec_cycles_alt,
  output logic [7:0]       dec_operand,
  output logic [3:0]       dec_shift,
  output logic             dec_acc_high,
  output logic [2:0]       dec_bit_sel,
  output logic [1:0]       dec_ret_tp,
  output logic [3:0]       dec_ret_cond,
  output logic [15:0]      dec_imm16
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic        aw_hold;
  logic        w_hold;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic        w_lane0;
  logic        ctrl_en;
  logic        abort;
  logic [31:0] dec_count;
  logic [15:0] last_word;
  logic        last_bad;
  dsd_pkg::dsd_state_e state;

  wire wr_go = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      aw_hold       <= 1'b0;
      aw_addr       <= '0;
    end
    else if (s_axi_awready && s_axi_awvalid)
    begin
      s_axi_awready <= 1'b0;
      aw_hold       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_hold <= 1'b0;
    else if (!aw_hold && !s_axi_bvalid)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b0;
      w_hold       <= 1'b0;
      w_data       <= '0;
      w_lane0      <= 1'b0;
    end
    else if (s_axi_wready && s_axi_wvalid)
    begin
      s_axi_wready <= 1'b0;
      w_hold       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_lane0      <= s_axi_wstrb[0];
    end
    else if (wr_go)
      w_hold <= 1'b0;
    else if (!w_hold && !s_axi_bvalid)
      s_axi_wready <= 1'b1;
  end

  // Write commit and response; only byte lane 0 carries control bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dsd_pkg::RESP_OKAY;
      ctrl_en      <= dsd_pkg::RESET_EN;
      abort        <= 1'b0;
    end
    else
    begin
      abort <= 1'b0;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= dsd_pkg::RESP_OKAY;
        unique case (aw_addr)
          dsd_pkg::REG_CTRL:
            if (w_lane0)
            begin
              ctrl_en <= w_data[dsd_pkg::CTRL_EN];
              abort   <= w_data[dsd_pkg::CTRL_ABORT];
            end
          dsd_pkg::REG_STATUS, dsd_pkg::REG_COUNT, dsd_pkg::REG_LAST: ;
          default: s_axi_bresp <= dsd_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= dsd_pkg::RESP_OKAY;
    end
    else if (s_axi_arready && s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= dsd_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        dsd_pkg::REG_CTRL:   s_axi_rdata <= {31'h0, ctrl_en};
        dsd_pkg::REG_STATUS:
          s_axi_rdata <= {19'h0, dec_op, 6'h0, last_bad,
                          state == dsd_pkg::ST_SECOND};
        dsd_pkg::REG_COUNT:  s_axi_rdata <= dec_count;
        dsd_pkg::REG_LAST:   s_axi_rdata <= {16'h0, last_word};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= dsd_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  logic [4:0] next_op;
  logic [1:0] next_words;
  logic [2:0] next_cycles;
  logic [2:0] next_alt;
  logic [3:0] next_shift;
  logic       next_high;
  logic [2:0] next_bit;

  always_comb
  begin
    next_op     = dsd_pkg::OP_NONE;
    next_words  = dsd_pkg::WORDS_ONE;
    next_cycles = dsd_pkg::CYC_ONE;
    next_alt    = dsd_pkg::CYC_ONE;
    next_shift  = 4'h0;
    next_high   = 1'b0;
    next_bit    = dsd_pkg::SEL_CARRY;
    if (fetch_word == dsd_pkg::W_PULL_ACC)
      next_op = dsd_pkg::OP_PULL_ACC;
    else if (fetch_word == dsd_pkg::W_PUSH_ACC)
      next_op = dsd_pkg::OP_PUSH_ACC;
    else if (fetch_word == dsd_pkg::W_ACC_MINUS_P)
      next_op = dsd_pkg::OP_ACC_MINUS_P;
    else if (fetch_word == dsd_pkg::W_XOR_HIGH)
    begin
      next_op     = dsd_pkg::OP_XOR_HIGH;
      next_words  = dsd_pkg::WORDS_TWO;
      next_cycles = dsd_pkg::CYC_TWO;
      next_alt    = dsd_pkg::CYC_TWO;
    end
    else if (fetch_word[15:4] == dsd_pkg::T_SET_BIT)
    begin
      next_op = dsd_pkg::OP_SET_BIT;
      unique case (fetch_word[3:0])
        dsd_pkg::B_CARRY:      next_bit = dsd_pkg::SEL_CARRY;
        dsd_pkg::B_BLOCK_PROG: next_bit = dsd_pkg::SEL_BLOCK_PROG;
        dsd_pkg::B_INT_DIS:    next_bit = dsd_pkg::SEL_INT_DIS;
        dsd_pkg::B_OVF_MODE:   next_bit = dsd_pkg::SEL_OVF_MODE;
        dsd_pkg::B_TEST:       next_bit = dsd_pkg::SEL_TEST;
        dsd_pkg::B_EXT_FLAG:   next_bit = dsd_pkg::SEL_EXT_FLAG;
        dsd_pkg::B_SIGN_EXT:   next_bit = dsd_pkg::SEL_SIGN_EXT;
        default:               next_op  = dsd_pkg::OP_NONE;
      endcase
    end
    else if (fetch_word[15:4] == dsd_pkg::T_MINUS_LONG)
    begin
      next_op     = dsd_pkg::OP_MINUS_LONG;
      next_words  = dsd_pkg::WORDS_TWO;
      next_cycles = dsd_pkg::CYC_TWO;
      next_alt    = dsd_pkg::CYC_TWO;
      next_shift  = fetch_word[3:0];
    end
    else if (fetch_word[15:10] == dsd_pkg::T_COND_RETURN)
    begin
      next_op     = dsd_pkg::OP_COND_RETURN;
      next_cycles = dsd_pkg::CYC_RET_TAKEN;
      next_alt    = dsd_pkg::CYC_RET_SKIP;
    end
    else if (fetch_word[15:12] == dsd_pkg::N_STORE_ACC)
    begin
      next_high  = fetch_word[dsd_pkg::POS_HALF];
      next_op    = next_high ? dsd_pkg::OP_STORE_HIGH
                             : dsd_pkg::OP_STORE_LOW;
      next_shift = {1'b0, fetch_word[10:8]};
    end
    else if (fetch_word[15:12] == dsd_pkg::N_MINUS_SHIFT)
    begin
      next_op    = dsd_pkg::OP_MINUS_SHIFT;
      next_shift = fetch_word[11:8];
    end
    else
      unique case (fetch_word[15:8])
        dsd_pkg::H_PULL_MEM:     next_op = dsd_pkg::OP_PULL_MEM;
        dsd_pkg::H_SAVE_MEM:     next_op = dsd_pkg::OP_SAVE_MEM;
        dsd_pkg::H_REPEAT_IMM:   next_op = dsd_pkg::OP_REPEAT_IMM;
        dsd_pkg::H_REPEAT_MEM:   next_op = dsd_pkg::OP_REPEAT_MEM;
        dsd_pkg::H_AUX_MINUS:    next_op = dsd_pkg::OP_AUX_MINUS;
        dsd_pkg::H_P_SHIFT_SEL:  next_op = dsd_pkg::OP_P_SHIFT_SEL;
        dsd_pkg::H_SQUARE_MINUS: next_op = dsd_pkg::OP_SQUARE_MINUS;
        dsd_pkg::H_STATUS0:      next_op = dsd_pkg::OP_STATUS0;
        dsd_pkg::H_STATUS1:      next_op = dsd_pkg::OP_STATUS1;
        dsd_pkg::H_MINUS_BORROW: next_op = dsd_pkg::OP_MINUS_BORROW;
        dsd_pkg::H_MINUS_TEMP:   next_op = dsd_pkg::OP_MINUS_TEMP;
        dsd_pkg::H_MINUS_IMM:    next_op = dsd_pkg::OP_MINUS_IMM;
        dsd_pkg::H_CLR_LOAD_RND: next_op = dsd_pkg::OP_CLR_LOAD_RND;
        dsd_pkg::H_LONG_IMM:
        begin
          next_op     = dsd_pkg::OP_LONG_IMM;
          next_words  = dsd_pkg::WORDS_TWO;
          next_cycles = dsd_pkg::CYC_TWO;
          next_alt    = dsd_pkg::CYC_TWO;
        end
        default: next_op = dsd_pkg::OP_NONE;
      endcase
  end

  // ----------------------------------------------------------------
  // Word sequencing and result registers
  // ----------------------------------------------------------------
  wire take_first  = fetch_valid && fetch_ready &&
                     state == dsd_pkg::ST_FIRST;
  wire take_second = fetch_valid && fetch_ready &&
                     state == dsd_pkg::ST_SECOND;
  wire need_second = next_words == dsd_pkg::WORDS_TWO;

  logic [4:0] pend_op;
  logic [3:0] pend_shift;
  logic [7:0] pend_low;

  // Ready drops while disabled; a half-taken pair waits, abort drops it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fetch_ready <= 1'b0;
    else
      fetch_ready <= ctrl_en;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state      <= dsd_pkg::ST_FIRST;
      pend_op    <= dsd_pkg::OP_NONE;
      pend_shift <= 4'h0;
      pend_low   <= 8'h0;
    end
    else if (abort)
      state <= dsd_pkg::ST_FIRST;
    else if (take_first && need_second)
    begin
      state      <= dsd_pkg::ST_SECOND;
      pend_op    <= next_op;
      pend_shift <= next_shift;
      pend_low   <= fetch_word[7:0];
    end
    else if (take_second)
      state <= dsd_pkg::ST_FIRST;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dec_valid      <= 1'b0;
      dec_op         <= dsd_pkg::OP_NONE;
      dec_words      <= dsd_pkg::WORDS_ONE;
      dec_cycles     <= dsd_pkg::CYC_ONE;
      dec_cycles_alt <= dsd_pkg::CYC_ONE;
      dec_operand    <= 8'h0;
      dec_shift      <= 4'h0;
      dec_acc_high   <= 1'b0;
      dec_bit_sel    <= dsd_pkg::SEL_CARRY;
      dec_ret_tp     <= 2'h0;
      dec_ret_cond   <= 4'h0;
      dec_imm16      <= 16'h0;
    end
    else if (take_first && !need_second)
    begin
      dec_valid      <= 1'b1;
      dec_op         <= next_op;
      dec_words      <= next_words;
      dec_cycles     <= next_cycles;
      dec_cycles_alt <= next_alt;
      dec_operand    <= fetch_word[7:0];
      dec_shift      <= next_shift;
      dec_acc_high   <= next_high;
      dec_bit_sel    <= next_bit;
      dec_ret_tp     <= fetch_word[dsd_pkg::POS_TP_HI:dsd_pkg::POS_TP_LO];
      dec_ret_cond   <= fetch_word[3:0];
      dec_imm16      <= 16'h0;
    end
    else if (take_second && !abort)
    begin
      dec_valid      <= 1'b1;
      dec_op         <= pend_op;
      dec_words      <= dsd_pkg::WORDS_TWO;
      dec_cycles     <= dsd_pkg::CYC_TWO;
      dec_cycles_alt <= dsd_pkg::CYC_TWO;
      dec_operand    <= pend_low;
      dec_shift      <= pend_shift;
      dec_acc_high   <= 1'b0;
      dec_imm16      <= fetch_word;
    end
    else
      dec_valid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dec_count <= '0;
      last_word <= '0;
      last_bad  <= 1'b0;
    end
    else if (take_first)
    begin
      last_word <= fetch_word;
      last_bad  <= next_op == dsd_pkg::OP_NONE;
      if (!need_second)
        dec_count <= dec_count + 32'h1;
    end
    else if (take_second && !abort)
      dec_count <= dec_count + 32'h1;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_first(logic [15:0] w);
    take_first && fetch_word == w;
  endsequence

  sequence s_first_hi(logic [7:0] h);
    take_first && fetch_word[15:8] == h;
  endsequence

  property p_one_hi(logic [7:0] h, logic [4:0] op);
    s_first_hi(h) |=> dec_valid && dec_op == op &&
      dec_words == dsd_pkg::WORDS_ONE && dec_cycles == dsd_pkg::CYC_ONE;
  endproperty

  chk_pull_acc: assert property (s_first(16'hBE32) |=> dec_valid &&
    dec_op == dsd_pkg::OP_PULL_ACC && dec_cycles == dsd_pkg::CYC_ONE)
    else $error("pull to accumulator misdecoded");
  chk_pull_mem: assert property (p_one_hi(8'h8A,
    dsd_pkg::OP_PULL_MEM)) else $error("pull to memory misdecoded");
  chk_save_mem: assert property (p_one_hi(8'h76,
    dsd_pkg::OP_SAVE_MEM)) else $error("memory push misdecoded");
  chk_cond_ret: assert property (take_first &&
    fetch_word[15:10] == 6'h3B |=> dec_op == dsd_pkg::OP_COND_RETURN &&
    dec_cycles == 3'h4 && dec_cycles_alt == 3'h2 &&
    dec_ret_cond == $past(fetch_word[3:0]))
    else $error("conditional return misdecoded");
  chk_repeat_mem: assert property (p_one_hi(8'h0B,
    dsd_pkg::OP_REPEAT_MEM)) else $error("memory repeat misdecoded");
  chk_store_half: assert property (take_first &&
    fetch_word[15:12] == 4'h9 |=> dec_acc_high == $past(fetch_word[11]) &&
    dec_shift == {1'b0, $past(fetch_word[10:8])})
    else $error("accumulator store fields wrong");
  chk_set_carry: assert property (s_first(16'hBE4F) |=>
    dec_op == dsd_pkg::OP_SET_BIT && dec_bit_sel == dsd_pkg::SEL_CARRY)
    else $error("set carry misdecoded");
  chk_minus_shift: assert property (take_first &&
    fetch_word[15:12] == 4'h3 |=> dec_op == dsd_pkg::OP_MINUS_SHIFT &&
    dec_shift == $past(fetch_word[11:8]))
    else $error("shifted subtract misdecoded");
  chk_long_pair: assert property (s_first_hi(8'hAE) ##1
    (take_second && !abort)
    |=> dec_valid && dec_op == dsd_pkg::OP_LONG_IMM &&
    dec_words == 2'h2 && dec_imm16 == $past(fetch_word))
    else $error("long immediate pair lost");
  chk_no_early: assert property (s_first(16'hBE83) |=> !dec_valid)
    else $error("two-word op issued before its constant");
  chk_operand: assert property (take_first && !need_second |=>
    dec_operand == $past(fetch_word[7:0]))
    else $error("operand byte altered");
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for dsd_decoder: an opcode model is compared at
// each decode; registers are reached over AXI4-Lite. Needs dsd_pkg.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        aclk, aresetn, fetch_valid, fetch_ready, dec_valid;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, dec_acc_high;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dec_words, dec_ret_tp;
  logic [2:0]  dec_cycles, dec_cycles_alt, dec_bit_sel;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, dec_shift;
  logic [3:0]  dec_ret_cond;
  logic [4:0]  dec_op;
  logic [7:0]  dec_operand;
  logic [15:0] fetch_word, dec_imm16, w0;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          error_cnt, total_checks, seed, n_dec;
  // Decode table: care mask, value, expected operation code
  logic [39:0] dtab [23] = '{40'hFFFFBE3201, 40'hFFFFBE3C04, 40'hFFFFBE050C,
    40'hFFFFBE8317, 40'hFFF0BFA013, 40'hFF00BF000D, 40'hFF008A0002,
    40'hFF00760003, 40'hFF00BB0006, 40'hFF000B0007, 40'hFF007C000A,
    40'hFF0053000E, 40'hFF008E000F, 40'hFF008F0010, 40'hFF00AE0011,
    40'hFF00640014, 40'hFF00670015, 40'hFF00BA0016, 40'hFF00680018,
    40'hF800980008, 40'hF800900009, 40'hF000300012, 40'hFC00EC0005};
  // Stimulus: fixed opcode bits, then mask of bits left random
  logic [31:0] stab [29] = '{32'hBE320000, 32'h8A0000FF, 32'h760000FF,
    32'hBE3C0000, 32'hEC0003FF, 32'hBB0000FF, 32'h0B0000FF, 32'h980007FF,
    32'h900007FF, 32'h7C0000FF, 32'hBE4F0000, 32'hBE450000, 32'hBE410000,
    32'hBE430000, 32'hBE4B0000, 32'hBE4D0000, 32'hBE470000, 32'hBE400000,
    32'hBE050000, 32'hBF00005F, 32'h530000FF, 32'h8E0000FF, 32'h8F0000FF,
    32'hAE0000FF, 32'h30000FFF, 32'hBFA0000F, 32'h640000FF, 32'h670000FF,
    32'hBE830000};
  dsd_decoder i_dsd_decoder (.*);
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic ck(input logic [31:0] e, input logic [31:0] a);
    total_checks++;
    if (e !== a)
    begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 40)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask
  // ---------------------------------------------------------------
  // Bus and fetch drivers
  // ---------------------------------------------------------------
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && ++n < 40);
    tmo(n);
    s_axi_bready <= 1'b0;
    ck(er, s_axi_bresp);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && ++n < 40);
    tmo(n);
    s_axi_rready <= 1'b0;
    ck(e, s_axi_rdata);
    ck(er, s_axi_rresp);
  endtask
  task automatic fw(input logic [15:0] w);
    int n;
    n = 0;
    fetch_valid <= 1'b1;
    fetch_word <= w;
    do @(posedge aclk); while (!fetch_ready && ++n < 40);
    tmo(n);
  endtask
  // Decode one instruction and compare op, operand, constant, words, cycles and the op's own fields with the model
  task automatic dec(input logic [15:0] w, input logic [15:0] k);
    int n, s, two, cy;
    logic [4:0] op;
    op = 5'h00;
    s = -1;
    for (int i = 0; i < 7; i++)
      if (((28'hF513BD7 >> (24 - 4 * i)) & 28'hF) == w[3:0]) s = i;
    for (int i = 22; i >= 0; i--)
      if ((w & dtab[i][39:24]) == dtab[i][23:8]) op = dtab[i][4:0];
    if (w[15:4] == 12'hBE4) op = (s < 0) ? 5'h00 : 5'h0B;
    two = (op == 5'h11 || op == 5'h13 || op == 5'h17);
    cy = (op == 5'h05) ? 4 : two ? 2 : 1;
    n = 0;
    fw(w);
    if (two) fw(k);
    fetch_valid <= 1'b0;
    do @(posedge aclk); while (!dec_valid && ++n < 40);
    tmo(n);
    ck(op, dec_op);
    ck(w[7:0], dec_operand);
    ck(two ? k : 16'h0, dec_imm16);
    ck(two ? 2 : 1, dec_words);
    ck(cy, dec_cycles);
    ck(op == 5'h05 ? 2 : cy, dec_cycles_alt);
    if (op == 5'h08 || op == 5'h09)
      ck(w[11:8], {dec_acc_high, dec_shift[2:0]});
    if (op == 5'h12) ck(w[11:8], dec_shift);
    if (op == 5'h13) ck(w[3:0], dec_shift);
    if (op == 5'h05)
      ck({w[9:8], w[3:0]}, {dec_ret_tp, dec_ret_cond});
    if (op == 5'h0B) ck(s, dec_bit_sel);
    n_dec++;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    seed = 18620;
    {aresetn, fetch_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, fetch_word, s_axi_wdata} = '0;
    {s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(4'h0, 32'h1, 2'h0);
    axr(4'h2, 32'h0, 2'h2);
    axw(4'h2, 32'h0, 2'h2);
    $display("test register reset done");
    for (int r = 0; r < 2; r++)
      for (int i = 0; i < 29; i++)
      begin
        w0 = stab[i][31:16] | (stab[i][15:0] & 16'($random(seed)));
        dec(w0, 16'($random(seed)));
      end
    $display("test decode done");
    axr(4'h8, n_dec, 2'h0);
    axr(4'hC, w0, 2'h0);
    axr(4'h4, 32'h1700, 2'h0);
    axw(4'h0, 32'h0, 2'h0);
    repeat (3) @(posedge aclk);
    ck(1'b0, fetch_ready);
    axw(4'h0, 32'h1, 2'h0);
    repeat (3) @(posedge aclk);
    ck(1'b1, fetch_ready);
    $display("test enable done");
    // A lone first word waits; abort must drop it without a decode
    fw(16'hAE12);
    fetch_valid <= 1'b0;
    axr(4'h4, 32'h1701, 2'h0);
    axw(4'h0, 32'h3, 2'h0);
    axr(4'h4, 32'h1700, 2'h0);
    axr(4'hC, 32'hAE12, 2'h0);
    axr(4'h8, n_dec, 2'h0);
    $display("test abort done");
    end_of_test();
  end
endmodule
`default_nettype wire
